// ===== pkg/path_alarm_pkg.sv
package path_alarm_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 8;
    localparam logic [7:0] BASE_OFFSET = 8'h10;
    localparam logic [7:0] STATUS_CTRL_OFFSET = 8'h10;
    localparam logic [7:0] ALARM_IRQ_STATUS_OFFSET = 8'h11;
    localparam logic [7:0] POINTER_IRQ_STATUS_OFFSET = 8'h12;
    localparam logic [7:0] ALARM_IRQ_ENABLE_OFFSET = 8'h13;
    localparam logic [7:0] POINTER_IRQ_ENABLE_OFFSET = 8'h14;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int NEW_POINTER_EN_BIT = 0;
    localparam int NEW_POINTER_FLAG_BIT = 1;
    localparam int CTRL_RESERVED_BIT = 7;
    localparam int ALARM_STATE_LSB = 2;
    localparam int ALARM_STATE_COUNT = 5;
    localparam int EVENT_COUNT = 8;

    // ****************************************
    // Receive-side events and bus request
    // ****************************************
    typedef struct packed {
        logic concat_pointer_loss_state;
        logic pointer_loss_state;
        logic concat_alarm_sig_state;
        logic path_alarm_sig_state;
        logic far_rx_fail_state;
    } alarm_state_type;

    typedef struct packed {
        logic illegal_justify;
        logic concat_indicator_err;
        logic offset_jump;
        logic bad_new_data_flag;
        logic reserved;
        logic neg_justify;
        logic pos_justify;
        logic new_data_flag;
    } pointer_event_type;

    typedef struct packed {
        logic new_pointer;
        logic far_block_err;
        logic parity_err;
    } error_event_type;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
        logic write;
        logic read;
    } bus_req_type;

endpackage : path_alarm_pkg

// ===== hdl/path_alarm_irq.sv
`timescale 1ns/1ps
module path_alarm_irq #(
    parameter logic [7:0] BASE = path_alarm_pkg::BASE_OFFSET
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire path_alarm_pkg::bus_req_type bus_i,
    output logic [path_alarm_pkg::DATA_WIDTH-1:0] rdata_o,
    input wire path_alarm_pkg::alarm_state_type alarm_state_i,
    input wire path_alarm_pkg::error_event_type error_event_i,
    input wire path_alarm_pkg::pointer_event_type pointer_event_i,
    input wire logic concat_mode_i,
    output logic irq_out_n_o,
    output logic irq_summary_o
);
    import path_alarm_pkg::*;

    // ****************************************
    // State
    // ****************************************
    alarm_state_type alarm_state;
    alarm_state_type alarm_prev;
    alarm_state_type change_flag;
    logic far_block_err_flag;
    logic parity_err_flag;
    logic new_pointer_flag;
    logic new_pointer_irq_en;
    logic ctrl_reserved;
    logic [7:0] path_alarm_irq_enable;
    logic [7:0] pointer_event_irq_enable;
    pointer_event_type pointer_flags;
    logic [7:0] rdata;
    logic irq_out_n;
    logic irq_summary;

    alarm_state_type next_alarm_state;
    alarm_state_type next_alarm_prev;
    alarm_state_type next_change_flag;
    logic next_far_block_err_flag;
    logic next_parity_err_flag;
    logic next_new_pointer_flag;
    logic next_new_pointer_irq_en;
    logic next_ctrl_reserved;
    logic [7:0] next_path_alarm_irq_enable;
    logic [7:0] next_pointer_event_irq_enable;
    pointer_event_type next_pointer_flags;
    logic [7:0] next_rdata;
    logic next_irq_out_n;
    logic next_irq_summary;

    logic rd_ctrl;
    logic rd_alarm;
    logic rd_pointer;
    logic [7:0] alarm_status_word;
    logic [7:0] pointer_status_word;
    logic pending;
    logic rd_alarm_en;
    logic rd_pointer_en;
    logic wr_ctrl;
    logic wr_alarm_en;
    logic wr_pointer_en;
    logic ctrl_pending;
    logic alarm_pending;
    logic pointer_pending;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
        hit = (addr == (BASE + offset - BASE_OFFSET));
    endfunction : hit

    // Set wins over read-clear
    function automatic logic sticky(input logic flag, input logic clr, input logic set);
        sticky = set | (flag & ~clr);
    endfunction : sticky

    // Vector form for the alarm change flags
    function automatic logic [ALARM_STATE_COUNT-1:0] sticky_vec5(
        input logic [ALARM_STATE_COUNT-1:0] flag,
        input logic clr,
        input logic [ALARM_STATE_COUNT-1:0] set
    );
        sticky_vec5 = set | (flag & {ALARM_STATE_COUNT{~clr}});
    endfunction : sticky_vec5

    // Alarm status layout, reserved bit reads zero
    function automatic logic [7:0] alarm_word(
        input alarm_state_type change,
        input logic parity,
        input logic far_block
    );
        alarm_word = {1'b0, change, parity, far_block};
    endfunction : alarm_word

    // ****************************************
    // Bus decode
    // ****************************************
    always_comb begin
        rd_ctrl = bus_i.read & hit(bus_i.addr, STATUS_CTRL_OFFSET);
        rd_alarm = bus_i.read & hit(bus_i.addr, ALARM_IRQ_STATUS_OFFSET);
        rd_pointer = bus_i.read & hit(bus_i.addr, POINTER_IRQ_STATUS_OFFSET);
        rd_alarm_en = bus_i.read & hit(bus_i.addr, ALARM_IRQ_ENABLE_OFFSET);
        rd_pointer_en = bus_i.read & hit(bus_i.addr, POINTER_IRQ_ENABLE_OFFSET);
        wr_ctrl = bus_i.write & hit(bus_i.addr, STATUS_CTRL_OFFSET);
        wr_alarm_en = bus_i.write & hit(bus_i.addr, ALARM_IRQ_ENABLE_OFFSET);
        wr_pointer_en = bus_i.write & hit(bus_i.addr, POINTER_IRQ_ENABLE_OFFSET);
    end

    // ****************************************
    // Alarm levels
    // ****************************************
    always_comb begin
        // Same clock domain, so no synchroniser
        next_alarm_state = alarm_state_i;
        next_alarm_prev = alarm_state;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_state <= '0;
            alarm_prev <= '0;
        end else begin
            alarm_state <= next_alarm_state;
            alarm_prev <= next_alarm_prev;
        end
    end

    // ****************************************
    // Alarm interrupt status
    // ****************************************
    always_comb begin
        next_change_flag = alarm_state_type'(sticky_vec5(change_flag, rd_alarm,
            alarm_state ^ alarm_prev));
        next_far_block_err_flag = sticky(far_block_err_flag, rd_alarm,
            error_event_i.far_block_err);
        next_parity_err_flag = sticky(parity_err_flag, rd_alarm,
            error_event_i.parity_err);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            change_flag <= '0;
            far_block_err_flag <= 1'b0;
            parity_err_flag <= 1'b0;
        end else begin
            change_flag <= next_change_flag;
            far_block_err_flag <= next_far_block_err_flag;
            parity_err_flag <= next_parity_err_flag;
        end
    end

    // ****************************************
    // Status and control register
    // ****************************************
    always_comb begin
        next_new_pointer_flag = sticky(new_pointer_flag, rd_ctrl,
            error_event_i.new_pointer);
        next_new_pointer_irq_en = new_pointer_irq_en;
        next_ctrl_reserved = ctrl_reserved;
        if (wr_ctrl) begin
            next_new_pointer_irq_en = bus_i.wdata[NEW_POINTER_EN_BIT];
            next_ctrl_reserved = bus_i.wdata[CTRL_RESERVED_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            new_pointer_flag <= 1'b0;
            new_pointer_irq_en <= 1'b0;
            ctrl_reserved <= 1'b0;
        end else begin
            new_pointer_flag <= next_new_pointer_flag;
            new_pointer_irq_en <= next_new_pointer_irq_en;
            ctrl_reserved <= next_ctrl_reserved;
        end
    end

    // ****************************************
    // Pointer interrupt status
    // ****************************************
    always_comb begin
        next_pointer_flags = pointer_flags;
        next_pointer_flags.new_data_flag = sticky(pointer_flags.new_data_flag, rd_pointer,
            pointer_event_i.new_data_flag);
        next_pointer_flags.pos_justify = sticky(pointer_flags.pos_justify, rd_pointer,
            pointer_event_i.pos_justify);
        next_pointer_flags.neg_justify = sticky(pointer_flags.neg_justify, rd_pointer,
            pointer_event_i.neg_justify);
        next_pointer_flags.reserved = 1'b0;
        next_pointer_flags.bad_new_data_flag = sticky(pointer_flags.bad_new_data_flag,
            rd_pointer, pointer_event_i.bad_new_data_flag);
        next_pointer_flags.offset_jump = sticky(pointer_flags.offset_jump, rd_pointer,
            pointer_event_i.offset_jump);
        next_pointer_flags.concat_indicator_err = sticky(pointer_flags.concat_indicator_err,
            rd_pointer, pointer_event_i.concat_indicator_err & concat_mode_i);
        next_pointer_flags.illegal_justify = sticky(pointer_flags.illegal_justify,
            rd_pointer, pointer_event_i.illegal_justify);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pointer_flags <= '0;
        end else begin
            pointer_flags <= next_pointer_flags;
        end
    end

    // ****************************************
    // Interrupt enables
    // ****************************************
    always_comb begin
        next_path_alarm_irq_enable = path_alarm_irq_enable;
        next_pointer_event_irq_enable = pointer_event_irq_enable;
        if (wr_alarm_en) begin
            next_path_alarm_irq_enable = bus_i.wdata;
        end
        if (wr_pointer_en) begin
            next_pointer_event_irq_enable = bus_i.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            path_alarm_irq_enable <= ENABLE_RESET;
            pointer_event_irq_enable <= ENABLE_RESET;
        end else begin
            path_alarm_irq_enable <= next_path_alarm_irq_enable;
            pointer_event_irq_enable <= next_pointer_event_irq_enable;
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_comb begin
        // Status words as seen by software
        alarm_status_word = alarm_word(change_flag, parity_err_flag,
            far_block_err_flag);
        pointer_status_word = pointer_flags;
        next_rdata = READ_UNMAPPED;
        if (rd_ctrl) begin
            next_rdata = {ctrl_reserved, alarm_state, new_pointer_flag, new_pointer_irq_en};
        end else if (rd_alarm) begin
            next_rdata = alarm_status_word;
        end else if (rd_pointer) begin
            next_rdata = pointer_status_word;
        end else if (rd_alarm_en) begin
            next_rdata = path_alarm_irq_enable;
        end else if (rd_pointer_en) begin
            next_rdata = pointer_event_irq_enable;
        end else begin
            next_rdata = READ_UNMAPPED;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata <= READ_UNMAPPED;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ****************************************
    // Interrupt output
    // ****************************************
    always_comb begin
        // From the flag values that will stand after this edge
        ctrl_pending = next_new_pointer_flag & next_new_pointer_irq_en;
        alarm_pending = |(alarm_word(next_change_flag, next_parity_err_flag,
            next_far_block_err_flag) & next_path_alarm_irq_enable);
        pointer_pending = |(next_pointer_flags & next_pointer_event_irq_enable);
        pending = ctrl_pending | alarm_pending | pointer_pending;
        next_irq_out_n = ~pending;
        next_irq_summary = pending;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_out_n <= 1'b1;
            irq_summary <= 1'b0;
        end else begin
            irq_out_n <= next_irq_out_n;
            irq_summary <= next_irq_summary;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rdata_o = rdata;
    assign irq_out_n_o = irq_out_n;
    assign irq_summary_o = irq_summary;

endmodule : path_alarm_irq

// ===== verif/path_alarm_irq_checker.sv
`timescale 1ns/1ps
module path_alarm_irq_checker #(
    parameter logic [7:0] BASE = path_alarm_pkg::BASE_OFFSET
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire path_alarm_pkg::bus_req_type bus_i,
    input wire logic [path_alarm_pkg::DATA_WIDTH-1:0] rdata_o,
    input wire path_alarm_pkg::alarm_state_type alarm_state_i,
    input wire path_alarm_pkg::error_event_type error_event_i,
    input wire path_alarm_pkg::pointer_event_type pointer_event_i,
    input wire logic concat_mode_i,
    input wire logic irq_out_n_o,
    input wire logic irq_summary_o
);
    import path_alarm_pkg::*;
    // ****************************************
    // Shadow of enables
    // ****************************************
    logic [7:0] alarm_en;
    logic [7:0] ptr_en;
    logic np_en;
    logic [7:0] ptr_live;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_en <= 8'h00;
            ptr_en <= 8'h00;
            np_en <= 1'b0;
        end else if (bus_i.write) begin
            if (bus_i.addr == BASE) np_en <= bus_i.wdata[0];
            if (bus_i.addr == BASE + 8'h03) alarm_en <= bus_i.wdata;
            if (bus_i.addr == BASE + 8'h04) ptr_en <= bus_i.wdata;
        end
    end
    assign ptr_live = pointer_event_i & ptr_en & {1'b1, concat_mode_i, 6'h37};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_summary_match: assert property (irq_summary_o == !irq_out_n_o)
        else $error("summary differs from irq");
    a_rdata_idle: assert property (!bus_i.read |=> rdata_o == 8'h00)
        else $error("read data not idle");
    a_unmapped_read: assert property (bus_i.read && (bus_i.addr < BASE ||
        bus_i.addr > BASE + 8'h04) |=> rdata_o == 8'h00) else $error("unmapped read");
    a_alarm_state_read: assert property (bus_i.read && bus_i.addr == BASE &&
        !$past(rst_i) && $stable(alarm_state_i) |=> rdata_o[6:2] == $past(alarm_state_i))
        else $error("alarm state bits wrong");
    a_error_irq: assert property (!bus_i.write && (error_event_i.parity_err && alarm_en[1] ||
        error_event_i.far_block_err && alarm_en[0]) |=> !irq_out_n_o) else $error("error irq");
    a_new_ptr_irq: assert property (error_event_i.new_pointer && np_en && !bus_i.write
        |=> !irq_out_n_o) else $error("new pointer irq");
    a_pointer_irq: assert property (|ptr_live && !bus_i.write |=> !irq_out_n_o)
        else $error("pointer irq");
    a_alarm_change_irq: assert property ((|((alarm_state_i ^ $past(alarm_state_i)) &
        alarm_en[6:2])) ##0 (!bus_i.write)[*3] |=> !irq_out_n_o) else $error("change irq");
    a_irq_release: assert property ($rose(irq_out_n_o) && !$past(rst_i) |->
        $past(bus_i.read || bus_i.write)) else $error("irq released without access");
    a_reset_idle: assert property ($fell(rst_i) |-> irq_out_n_o && rdata_o == 8'h00)
        else $error("not idle after reset");
    c_error_irq: cover property (error_event_i.parity_err && alarm_en[1]);
    c_pointer_irq: cover property (|ptr_live);
    c_irq_release: cover property ($rose(irq_out_n_o));
endmodule : path_alarm_irq_checker
bind path_alarm_irq path_alarm_irq_checker #(.BASE(BASE)) path_alarm_irq_checker_i (
    .clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .alarm_state_i(alarm_state_i), .error_event_i(error_event_i),
    .pointer_event_i(pointer_event_i), .concat_mode_i(concat_mode_i),
    .irq_out_n_o(irq_out_n_o), .irq_summary_o(irq_summary_o));

// ===== verif/path_alarm_irq_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module path_alarm_irq_tb;
    import path_alarm_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    bus_req_type bus = '0;
    logic [7:0] rdata;
    alarm_state_type alarm = '0;
    error_event_type err_ev = '0;
    pointer_event_type ptr_ev = '0;
    logic concat_mode = 1'b1;
    logic irq_n;
    logic irq_sum;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int i;
    always #5 clk_i = ~clk_i;
    path_alarm_irq path_alarm_irq_i (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus),
        .rdata_o(rdata), .alarm_state_i(alarm), .error_event_i(err_ev),
        .pointer_event_i(ptr_ev), .concat_mode_i(concat_mode), .irq_out_n_o(irq_n),
        .irq_summary_o(irq_sum));
    // ****************************************
    // Bus and event tasks
    // ****************************************
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i);
        bus.write <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        bus.read <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : rd
    task irq_is(input logic e);
        `CHK(irq_n, e)
        `CHK(irq_sum, ~e)
    endtask : irq_is
    task ev(input error_event_type e, input pointer_event_type p);
        @(posedge clk_i);
        err_ev <= e;
        ptr_ev <= p;
        @(posedge clk_i);
        err_ev <= '0;
        ptr_ev <= '0;
        #1;
    endtask : ev
    task final_report;
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    always @(posedge clk_i) begin
        cycles++;
        if (cycles > 5000) begin
            err_count++;
            final_report();
        end
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 6; i++) rd(BASE_OFFSET + i[7:0], 8'h00);
        irq_is(1'b1);
        wr(8'h10, 8'h01);
        ev(3'b100, '0);
        irq_is(1'b0);
        rd(8'h10, 8'h03);
        irq_is(1'b1);
        rd(8'h10, 8'h01);
        wr(8'h13, 8'h7f);
        ev(3'b011, '0);
        irq_is(1'b0);
        rd(8'h11, 8'h03);
        irq_is(1'b1);
        for (i = 0; i < 5; i++) begin
            @(posedge clk_i);
            alarm <= 5'h01 << i;
            repeat (3) @(posedge clk_i);
            #1;
            irq_is(1'b0);
            rd(8'h10, 8'h01 | (8'h04 << i));
            rd(8'h11, 8'h04 << i);
            @(posedge clk_i);
            alarm <= '0;
            repeat (3) @(posedge clk_i);
            rd(8'h11, 8'h04 << i);
            irq_is(1'b1);
        end
        wr(8'h14, 8'hf7);
        for (i = 0; i < 8; i++) if (i != 3) begin
            ev('0, 8'h01 << i);
            irq_is(1'b0);
            rd(8'h12, 8'h01 << i);
            irq_is(1'b1);
        end
        @(posedge clk_i);
        concat_mode <= 1'b0;
        ev('0, 8'h48);
        irq_is(1'b1);
        rd(8'h12, 8'h00);
        wr(8'h14, 8'h00);
        ev('0, 8'h02);
        irq_is(1'b1);
        wr(8'h14, 8'h02);
        irq_is(1'b0);
        rd(8'h12, 8'h02);
        ev(3'b010, '0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        irq_is(1'b1);
        rd(8'h13, 8'h00);
        final_report();
    end
endmodule : path_alarm_irq_tb
